// ### shared/fpc_map.vh
/*
 * fpc_map.vh: codes, field values, tap masks and counts shared by the
 * fronthaul port and pattern configuration logic.
 * assumes it is included by bare name, definitions only.
 */
`ifndef FPC_MAP_VH
`define FPC_MAP_VH

// ****************************************************************
// port mode
// ****************************************************************
`define FPC_MODE_OFF      2'h0
`define FPC_MODE_NORMAL   2'h1
`define FPC_MODE_THROUGH  2'h2

// ****************************************************************
// line standard and frame content
// ****************************************************************
`define FPC_STD_CPRI      1'h0
`define FPC_STD_OBSAI     1'h1
`define FPC_CONT_UNFRAMED 2'h0
`define FPC_CONT_CPRI     2'h1
`define FPC_CONT_OBSAI    2'h2

// ****************************************************************
// timing source
// ****************************************************************
`define FPC_TSRC_INTERNAL 2'h0
`define FPC_TSRC_EXTERNAL 2'h1
`define FPC_TSRC_SAT      2'h2
`define FPC_TSRC_RECOV    2'h3

// ****************************************************************
// cpri rate options (index 1 to 10)
// ****************************************************************
`define FPC_RATE_FEC_LO   4'h9
`define FPC_RATE_FEC_HI   4'hA
`define FPC_RATE_V2_MIN   4'h5
`define FPC_PROTO_V1      2'h1
`define FPC_PROTO_V2      2'h2

// ****************************************************************
// pattern type: prbs order 15 to 31, else user or off
// ****************************************************************
`define FPC_PAT_OFF       5'h00
`define FPC_PAT_USER      5'h01
`define FPC_PAT_PRBS_MIN  5'h0F
`define FPC_PAT_PRBS_MAX  5'h1F
`define FPC_PAT_RESET     5'h0F

// ****************************************************************
// prbs feedback masks, bit p-1 set for tap p
// ****************************************************************
`define FPC_TAP_15 32'h00006000
`define FPC_TAP_16 32'h0000D008
`define FPC_TAP_17 32'h00012000
`define FPC_TAP_18 32'h00020400
`define FPC_TAP_19 32'h00072000
`define FPC_TAP_20 32'h00090000
`define FPC_TAP_21 32'h00140000
`define FPC_TAP_22 32'h00300000
`define FPC_TAP_23 32'h00420000
`define FPC_TAP_24 32'h00E10000
`define FPC_TAP_25 32'h01200000
`define FPC_TAP_26 32'h03880000
`define FPC_TAP_27 32'h07200000
`define FPC_TAP_28 32'h09000000
`define FPC_TAP_29 32'h14000000
`define FPC_TAP_30 32'h38000040
`define FPC_TAP_31 32'h48000000
`define FPC_SEED   32'hFFFFFFFF

// ****************************************************************
// checker lock counts (words)
// ****************************************************************
`define FPC_LOCK_WORDS    3'h4
`define FPC_LOSS_WORDS    3'h4

`endif

// ### hdl/fpc_buf2.v
/*
 * fpc_buf2.v: two-entry buffer with valid and ready on both sides.
 * assumes one clock; read data come straight from a register.
 */
`timescale 1ns/1ps
`default_nettype none

module fpc_buf2 #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             clock_in,
    input  wire             resetn_in,
    input  wire             ce_in,
    // fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);

    reg [WIDTH-1:0] head_q;
    reg [WIDTH-1:0] tail_q;
    reg [1:0]       count_q;
    wire            push;
    wire            pop;

    // ****************************************************************
    // storage
    // ****************************************************************
    // ready is the registered not-full, so the source stalls on full
    assign in_ready_out  = (count_q != 2'h2);
    assign out_valid_out = (count_q != 2'h0);
    assign out_data_out  = head_q;
    assign push = ce_in & in_valid_in & in_ready_out;
    assign pop  = ce_in & out_valid_out & out_ready_in;

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            head_q  <= {WIDTH{1'b0}};
            tail_q  <= {WIDTH{1'b0}};
            count_q <= 2'h0;
        end else if (ce_in) begin
            case ({push, pop})
                2'b10: begin
                    if (count_q == 2'h0) begin
                        head_q <= in_data_in;
                    end else begin
                        tail_q <= in_data_in;
                    end
                    count_q <= count_q + 2'h1;
                end
                2'b01: begin
                    head_q  <= tail_q;
                    count_q <= count_q - 2'h1;
                end
                2'b11: begin
                    if (count_q == 2'h1) begin
                        head_q <= in_data_in;
                    end else begin
                        head_q <= tail_q;
                        tail_q <= in_data_in;
                    end
                end
                default: begin
                    count_q <= count_q;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### hdl/fpc_port.v
/*
 * fpc_port.v: port mode, timing, fec, content and pattern configuration
 * of a fronthaul error tester port, with pattern generator and checker.
 * assumes tx and rx words come from logic on clock_in; clock presence
 * and negotiation results arrive from pins and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpc_map.vh"

module fpc_port #(
    parameter CM_W = 8
) (
    // clock, reset, enable
    input  wire            clock_in,
    input  wire            resetn_in,
    input  wire            ce_in,
    // port configuration
    input  wire [1:0]      port_mode_in,
    input  wire            line_std_in,
    input  wire [3:0]      line_rate_in,
    input  wire [1:0]      timing_src_in,
    input  wire            fec_enable_in,
    // frame and pattern configuration
    input  wire [1:0]      content_in,
    input  wire [4:0]      pattern_type_in,
    input  wire            invert_in,
    input  wire [31:0]     user_word_in,
    // cpri link configuration
    input  wire            startup_enable_in,
    input  wire            role_slave_in,
    input  wire [1:0]      protocol_in,
    input  wire [CM_W-1:0] cm_channel_in,
    // pins: clock presence and negotiation results
    input  wire            ext_clk_present_in,
    input  wire            sat_clk_present_in,
    input  wire            rec_clk_present_in,
    input  wire            neg_done_in,
    input  wire [3:0]      neg_rate_in,
    input  wire [1:0]      neg_protocol_in,
    input  wire [CM_W-1:0] neg_cm_in,
    // transmit stream
    output wire            tx_valid_out,
    input  wire            tx_ready_in,
    output wire [31:0]     tx_data_out,
    // receive stream
    input  wire            rx_valid_in,
    input  wire [31:0]     rx_data_in,
    // effective configuration and status
    output reg             tx_enable_out,
    output reg             tx_through_out,
    output reg  [1:0]      clk_select_out,
    output reg             clk_detected_out,
    output reg             fec_active_out,
    output reg  [1:0]      content_out,
    output reg  [4:0]      pattern_out,
    output reg             config_refused_out,
    output reg             cpri_link_active_out,
    output reg  [3:0]      link_rate_out,
    output reg  [1:0]      link_protocol_out,
    output reg  [CM_W-1:0] link_cm_out,
    output reg             rx_locked_out,
    output reg  [31:0]     pattern_errors_out
);

    // ****************************************************************
    // functions
    // ****************************************************************
    function [31:0] tap_mask;
        input [4:0] order;
        begin
            case (order)
                5'h0F:   tap_mask = `FPC_TAP_15;
                5'h10:   tap_mask = `FPC_TAP_16;
                5'h11:   tap_mask = `FPC_TAP_17;
                5'h12:   tap_mask = `FPC_TAP_18;
                5'h13:   tap_mask = `FPC_TAP_19;
                5'h14:   tap_mask = `FPC_TAP_20;
                5'h15:   tap_mask = `FPC_TAP_21;
                5'h16:   tap_mask = `FPC_TAP_22;
                5'h17:   tap_mask = `FPC_TAP_23;
                5'h18:   tap_mask = `FPC_TAP_24;
                5'h19:   tap_mask = `FPC_TAP_25;
                5'h1A:   tap_mask = `FPC_TAP_26;
                5'h1B:   tap_mask = `FPC_TAP_27;
                5'h1C:   tap_mask = `FPC_TAP_28;
                5'h1D:   tap_mask = `FPC_TAP_29;
                5'h1E:   tap_mask = `FPC_TAP_30;
                default: tap_mask = `FPC_TAP_31;
            endcase
        end
    endfunction

    // 32 shifts; afterwards the register holds exactly the 32 new bits
    function [31:0] prbs_step;
        input [31:0] state;
        input [4:0]  order;
        integer      i;
        reg   [31:0] s;
        reg   [31:0] m;
        begin
            s = state;
            m = tap_mask(order);
            for (i = 0; i < 32; i = i + 1) begin
                s = {s[30:0], ^(s & m)};
            end
            prbs_step = s;
        end
    endfunction

    function [5:0] popcount;
        input [31:0] w;
        integer      i;
        reg   [5:0]  c;
        begin
            c = 6'h00;
            for (i = 0; i < 32; i = i + 1) begin
                c = c + {5'h00, w[i]};
            end
            popcount = c;
        end
    endfunction

    function is_prbs;
        input [4:0] t;
        begin
            is_prbs = (t >= `FPC_PAT_PRBS_MIN);
        end
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    localparam SYN_W = 10 + CM_W;
    reg  [SYN_W-1:0] sync1_q;
    reg  [SYN_W-1:0] sync2_q;
    wire             ext_s = sync2_q[0];
    wire             sat_s = sync2_q[1];
    wire             rec_s = sync2_q[2];
    wire             done_s = sync2_q[3];
    wire [3:0]       nrate_s = sync2_q[7:4];
    wire [1:0]       nproto_s = sync2_q[9:8];
    wire [CM_W-1:0]  ncm_s = sync2_q[SYN_W-1:10];
    reg              done_d1_q;
    reg  [3:0]       neg_rate_q;
    reg  [1:0]       neg_proto_q;
    reg  [CM_W-1:0]  neg_cm_q;

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_q <= {SYN_W{1'b0}};
            sync2_q <= {SYN_W{1'b0}};
        end else if (ce_in) begin
            sync1_q <= {neg_cm_in, neg_protocol_in, neg_rate_in,
                        neg_done_in, rec_clk_present_in,
                        sat_clk_present_in, ext_clk_present_in};
            sync2_q <= sync1_q;
        end
    end

    // fields are captured on the rise of done, when they stand still
    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_d1_q   <= 1'b0;
            neg_rate_q  <= 4'h0;
            neg_proto_q <= 2'h0;
            neg_cm_q    <= {CM_W{1'b0}};
        end else if (ce_in) begin
            done_d1_q <= done_s;
            if (done_s && !done_d1_q) begin
                neg_rate_q  <= nrate_s;
                neg_proto_q <= nproto_s;
                neg_cm_q    <= ncm_s;
            end
        end
    end

    // ****************************************************************
    // effective configuration
    // ****************************************************************
    reg [1:0] content_d;
    reg [4:0] pattern_d;
    reg       refused_d;
    reg [1:0] clk_sel_d;
    reg       clk_det_d;
    reg       cpri_act_d;
    reg [1:0] proto_d;
    reg       content_ok;
    reg       pattern_ok;

    always @* begin
        content_d = content_in;
        if (port_mode_in == `FPC_MODE_THROUGH) begin
            content_d = `FPC_CONT_CPRI;
        end
        case (content_d)
            `FPC_CONT_UNFRAMED: content_ok = 1'b1;
            `FPC_CONT_CPRI:     content_ok = (line_std_in == `FPC_STD_CPRI);
            `FPC_CONT_OBSAI:    content_ok = (line_std_in == `FPC_STD_OBSAI);
            default:            content_ok = 1'b0;
        endcase
        if (!content_ok) begin
            content_d = content_out;
        end
        pattern_ok = is_prbs(pattern_type_in) ||
                     (((pattern_type_in == `FPC_PAT_USER) ||
                       (pattern_type_in == `FPC_PAT_OFF)) &&
                      (content_d != `FPC_CONT_UNFRAMED));
        pattern_d = pattern_ok ? pattern_type_in : pattern_out;
        if (!is_prbs(pattern_d) && content_d == `FPC_CONT_UNFRAMED) begin
            pattern_d = `FPC_PAT_RESET;
        end
        refused_d = !content_ok || !pattern_ok;
        cpri_act_d = (content_d == `FPC_CONT_CPRI) &&
                     (port_mode_in == `FPC_MODE_NORMAL);
        clk_sel_d = timing_src_in;
        if (port_mode_in == `FPC_MODE_THROUGH) begin
            clk_sel_d = `FPC_TSRC_RECOV;
        end else if (cpri_act_d && role_slave_in) begin
            clk_sel_d = `FPC_TSRC_RECOV;
        end
        case (clk_sel_d)
            `FPC_TSRC_EXTERNAL: clk_det_d = ext_s;
            `FPC_TSRC_SAT:      clk_det_d = sat_s;
            `FPC_TSRC_RECOV:    clk_det_d = rec_s;
            default:            clk_det_d = 1'b0;
        endcase
        if (protocol_in == `FPC_PROTO_V2 &&
            line_rate_in >= `FPC_RATE_V2_MIN) begin
            proto_d = `FPC_PROTO_V2;
        end else begin
            proto_d = `FPC_PROTO_V1;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_enable_out        <= 1'b0;
            tx_through_out       <= 1'b0;
            clk_select_out       <= `FPC_TSRC_INTERNAL;
            clk_detected_out     <= 1'b0;
            fec_active_out       <= 1'b0;
            content_out          <= `FPC_CONT_UNFRAMED;
            pattern_out          <= `FPC_PAT_RESET;
            config_refused_out   <= 1'b0;
            cpri_link_active_out <= 1'b0;
            link_rate_out        <= 4'h0;
            link_protocol_out    <= 2'h0;
            link_cm_out          <= {CM_W{1'b0}};
        end else if (ce_in) begin
            tx_enable_out  <= (port_mode_in != `FPC_MODE_OFF);
            tx_through_out <= (port_mode_in == `FPC_MODE_THROUGH);
            clk_select_out     <= clk_sel_d;
            clk_detected_out   <= clk_det_d;
            // the external rs codec on the block stream follows this flag
            fec_active_out <= fec_enable_in &&
                (line_std_in == `FPC_STD_CPRI) &&
                (port_mode_in != `FPC_MODE_OFF) &&
                (line_rate_in == `FPC_RATE_FEC_LO ||
                 line_rate_in == `FPC_RATE_FEC_HI);
            content_out          <= content_d;
            pattern_out          <= pattern_d;
            config_refused_out   <= refused_d;
            cpri_link_active_out <= cpri_act_d;
            if (!cpri_act_d) begin
                link_rate_out     <= 4'h0;
                link_protocol_out <= 2'h0;
                link_cm_out       <= {CM_W{1'b0}};
            end else if (startup_enable_in) begin
                link_rate_out     <= neg_rate_q;
                link_protocol_out <= neg_proto_q;
                link_cm_out       <= neg_cm_q;
            end else begin
                link_rate_out     <= line_rate_in;
                link_protocol_out <= proto_d;
                link_cm_out       <= cm_channel_in;
            end
        end
    end

    // ****************************************************************
    // pattern generator
    // ****************************************************************
    reg  [31:0] gen_state_q;
    wire [31:0] gen_next = prbs_step(gen_state_q, pattern_out);
    reg  [31:0] gen_word;
    wire        buf_ready;
    wire        gen_push;

    // generation runs only in normal mode; stalls when the buffer fills
    assign gen_push = tx_enable_out && !tx_through_out;

    always @* begin
        if (is_prbs(pattern_out)) begin
            gen_word = gen_next ^ {32{invert_in}};
        end else if (pattern_out == `FPC_PAT_USER) begin
            gen_word = user_word_in;
        end else begin
            gen_word = 32'h00000000;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            gen_state_q <= `FPC_SEED;
        end else if (ce_in && gen_push && buf_ready) begin
            gen_state_q <= gen_next;
        end
    end

    fpc_buf2 #(
        .WIDTH        (32)
    ) u_buf (
        .clock_in     (clock_in),
        .resetn_in    (resetn_in),
        .ce_in        (ce_in),
        .in_valid_in  (gen_push),
        .in_ready_out (buf_ready),
        .in_data_in   (gen_word),
        .out_valid_out(tx_valid_out),
        .out_ready_in (tx_ready_in & tx_enable_out),
        .out_data_out (tx_data_out)
    );

    // ****************************************************************
    // pattern checker
    // ****************************************************************
    reg  [31:0] rx_prev_q;
    reg  [2:0]  good_q;
    reg  [2:0]  bad_q;
    reg  [31:0] expect_w;
    reg         check_en;
    wire [5:0]  miss = popcount(rx_data_in ^ expect_w);

    // a prbs word predicts the next, so one wrong bit may count five times or more
    always @* begin
        check_en = 1'b1;
        if (is_prbs(pattern_out)) begin
            expect_w = prbs_step(rx_prev_q ^ {32{invert_in}}, pattern_out)
                       ^ {32{invert_in}};
        end else if (pattern_out == `FPC_PAT_USER) begin
            expect_w = user_word_in;
        end else begin
            expect_w = 32'h00000000;
            check_en = 1'b0;
        end
    end

    always @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_prev_q          <= 32'h00000000;
            good_q             <= 3'h0;
            bad_q              <= 3'h0;
            rx_locked_out      <= 1'b0;
            pattern_errors_out <= 32'h00000000;
        end else if (ce_in && rx_valid_in) begin
            rx_prev_q <= rx_data_in;
            if (!check_en) begin
                rx_locked_out <= 1'b0;
                good_q        <= 3'h0;
                bad_q         <= 3'h0;
            end else if (!rx_locked_out) begin
                if (miss != 6'h00) begin
                    good_q <= 3'h0;
                end else if (good_q == `FPC_LOCK_WORDS - 3'h1) begin
                    rx_locked_out <= 1'b1;
                    good_q        <= 3'h0;
                    bad_q         <= 3'h0;
                end else begin
                    good_q <= good_q + 3'h1;
                end
            end else begin
                if (pattern_errors_out > 32'hFFFFFFFF - {26'h0, miss}) begin
                    pattern_errors_out <= 32'hFFFFFFFF;
                end else begin
                    pattern_errors_out <= pattern_errors_out
                                          + {26'h0, miss};
                end
                if (miss == 6'h00) begin
                    bad_q <= 3'h0;
                end else if (bad_q == `FPC_LOSS_WORDS - 3'h1) begin
                    rx_locked_out <= 1'b0;
                    bad_q         <= 3'h0;
                end else begin
                    bad_q <= bad_q + 3'h1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### testbench/fpc_sva.sv
/* fpc_sva: timing checks on the fpc_port pins.
   assumes it is bound to fpc_port from the testbench top file. */
`timescale 1ns/1ps
`default_nettype none
`include "fpc_map.vh"
module fpc_sva (
    // inputs and outputs of the port block
    input wire logic        clock_in, resetn_in, ce_in, line_std_in,
    input wire logic        fec_enable_in, role_slave_in, tx_ready_in,
    input wire logic        tx_valid_out, tx_enable_out, tx_through_out,
    input wire logic        fec_active_out,
    input wire logic [1:0]  port_mode_in, timing_src_in, content_in,
    input wire logic [1:0]  clk_select_out, content_out, link_protocol_out,
    input wire logic [3:0]  line_rate_in, link_rate_out,
    input wire logic [31:0] tx_data_out, pattern_errors_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    sequence s_off; ce_in && port_mode_in == `FPC_MODE_OFF; endsequence
    sequence s_norm; ce_in && port_mode_in == `FPC_MODE_NORMAL; endsequence
    a_tx_off: assert property (s_off |=> !tx_enable_out)
        else $error("transmitter on in off mode");
    a_tx_normal: assert property (s_norm |=> tx_enable_out && !tx_through_out)
        else $error("normal mode not driving");
    a_through_cont: assert property (ce_in && port_mode_in == `FPC_MODE_THROUGH
        && !line_std_in |=> content_out == `FPC_CONT_CPRI)
        else $error("through mode content not forced");
    a_through_clk: assert property (ce_in && port_mode_in == `FPC_MODE_THROUGH
        |=> clk_select_out == `FPC_TSRC_RECOV) else $error("through clock");
    a_src_pick: assert property (s_norm and !role_slave_in
        |=> clk_select_out == $past(timing_src_in)) else $error("clock select");
    a_fec_gate: assert property (s_norm and fec_enable_in && !line_std_in
        |=> fec_active_out == ($past(line_rate_in) inside
        {`FPC_RATE_FEC_LO, `FPC_RATE_FEC_HI})) else $error("fec gate");
    a_slave_recov: assert property (s_norm and role_slave_in
        && !line_std_in && content_in == `FPC_CONT_CPRI
        && content_out == `FPC_CONT_CPRI
        |=> clk_select_out == `FPC_TSRC_RECOV) else $error("slave clock");
    a_v2_floor: assert property (link_rate_out < `FPC_RATE_V2_MIN
        |-> link_protocol_out != `FPC_PROTO_V2) else $error("version floor");
    a_err_mono: assert property (1'b1 |=> pattern_errors_out >=
        $past(pattern_errors_out)) else $error("error count fell");
    // a stalled word must not be lost or altered
    a_word_hold: assert property (ce_in && tx_valid_out && !tx_ready_in
        |=> tx_valid_out && $stable(tx_data_out)) else $error("word lost");
endmodule
`default_nettype wire

// ### testbench/fpc_partner.sv
/* fpc_partner: link partner that loops tx words back to rx.
   assumes one clock; negotiation fields never change, done rises late. */
`timescale 1ns/1ps
`default_nettype none
module fpc_partner (
    input wire logic        clock_in, resetn_in, stall_in,
    input wire logic        tx_valid_in, tx_enable_in,
    input wire logic [31:0] tx_data_in,
    output logic            tx_ready_out, rx_valid_out, neg_done_out,
    output logic [31:0]     rx_data_out,
    output logic [3:0]      neg_rate_out,
    output logic [1:0]      neg_proto_out
);
    logic [3:0] cnt_q;
    assign tx_ready_out = !stall_in;
    assign rx_valid_out = tx_valid_in && tx_ready_out && tx_enable_in;
    // idle data is the inverted tx word so a stale word is never mistaken for a match
    assign rx_data_out = rx_valid_out ? tx_data_in : ~tx_data_in;
    assign neg_rate_out = 4'h7;
    assign neg_proto_out = 2'h2;
    always @(posedge clock_in or negedge resetn_in)
        if (!resetn_in) cnt_q <= 4'h0;
        else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
    assign neg_done_out = (cnt_q == 4'hF);
endmodule
`default_nettype wire

// ### testbench/testbench.sv
/* testbench: directed checks of fpc_port with a loopback partner.
   assumes fpc_map.vh on the include path. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_in = 0, resetn_in = 0, line_std_in = 0, fec_enable_in = 0;
    logic startup_enable_in = 0, role_slave_in = 0, stall = 0;
    logic [1:0] port_mode_in = 2'h1, timing_src_in = 2'h0, content_in = 2'h1;
    logic [1:0] protocol_in = 2'h1;
    logic [3:0] line_rate_in = 4'h1;
    logic [4:0] pattern_type_in = 5'h0F;
    wire ce_in = 1'b1, invert_in = 1'b0, sat_clk_present_in = 1'b0;
    wire ext_clk_present_in = 1'b1, rec_clk_present_in = 1'b1;
    wire [31:0] user_word_in = 32'h0;
    wire [7:0] cm_channel_in = 8'h3C, neg_cm_in = 8'h2A, link_cm_out;
    wire tx_ready_in, rx_valid_in, neg_done_in, tx_valid_out, tx_enable_out;
    wire tx_through_out, clk_detected_out, fec_active_out, rx_locked_out;
    wire config_refused_out, cpri_link_active_out;
    wire [1:0] neg_protocol_in, clk_select_out, content_out, link_protocol_out;
    wire [3:0] neg_rate_in, link_rate_out;
    wire [4:0] pattern_out;
    wire [31:0] rx_data_in, tx_data_out, pattern_errors_out;
    int n_fail = 0, compares = 0, cyc = 0;
    fpc_port DUT (.*);
    fpc_partner u_far (.clock_in(clock_in), .resetn_in(resetn_in),
        .stall_in(stall), .tx_valid_in(tx_valid_out),
        .tx_enable_in(tx_enable_out), .tx_data_in(tx_data_out),
        .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in),
        .neg_done_out(neg_done_in), .rx_data_out(rx_data_in),
        .neg_rate_out(neg_rate_in), .neg_proto_out(neg_protocol_in));
    always #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task step(input int n); repeat (n) @(posedge clock_in); #1; endtask
    task finish_test;
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task t_stream;
        stall = 1; step(8);
        chk("tx_valid", 32'h1, tx_valid_out);
        stall = 0; step(30);
        chk("rx_locked", 32'h1, rx_locked_out);
        chk("pat_errors", 32'h0, pattern_errors_out);
        port_mode_in = 2'h0; step(2);
        chk("tx_enable", 32'h0, tx_enable_out);
        port_mode_in = 2'h1;
    endtask
    task t_clock;
        for (int s = 0; s < 4; s++) begin
            timing_src_in = s[1:0]; step(4);
            chk("clk_select", s, clk_select_out);
            chk("clk_detected", s == 1 || s == 3, clk_detected_out);
        end
        role_slave_in = 1; timing_src_in = 2'h0; step(3);
        chk("slave_select", 32'h3, clk_select_out);
        role_slave_in = 0; port_mode_in = 2'h2; content_in = 2'h0; step(3);
        chk("through_content", 32'h1, content_out);
        chk("through_select", 32'h3, clk_select_out);
        port_mode_in = 2'h1; content_in = 2'h1; step(2);
    endtask
    task t_fec;
        fec_enable_in = 1;
        for (int r = 8; r <= 10; r++) begin
            line_rate_in = r[3:0]; step(2);
            chk("fec_active", r >= 9, fec_active_out);
        end
        fec_enable_in = 0;
    endtask
    task t_pattern;
        content_in = 2'h0; step(2);
        pattern_type_in = 5'h01; step(2);
        chk("refused_user", 32'h1, config_refused_out);
        chk("pattern_kept", 32'hF, pattern_out);
        pattern_type_in = 5'h00; step(2);
        chk("refused_off", 32'h1, config_refused_out);
        pattern_type_in = 5'h0F; content_in = 2'h1; step(2);
    endtask
    task t_link;
        protocol_in = 2'h2; line_rate_in = 4'h4; step(3);
        chk("proto_low", 32'h1, link_protocol_out);
        line_rate_in = 4'h5; step(3);
        chk("proto_v2", 32'h2, link_protocol_out);
        chk("rate_manual", 32'h5, link_rate_out);
        chk("cm_manual", 32'h3C, link_cm_out);
        startup_enable_in = 1; step(4);
        chk("rate_neg", 32'h7, link_rate_out);
        chk("proto_neg", 32'h2, link_protocol_out);
        chk("cm_neg", 32'h2A, link_cm_out);
    endtask
    initial begin
        step(6);
        resetn_in = 1;
        step(2);
        t_stream;
        t_clock;
        t_fec;
        t_pattern;
        t_link;
        finish_test;
    end
endmodule
bind fpc_port fpc_sva u_sva (.*);
`default_nettype wire
